/* File: hdl/mcr_ref_status.v */
/*
 * read-only bank of control references and initial speed detection
 * status for a sensorless field-oriented motor controller.
 * assumes the control algorithm drives the update strobes and values on
 * sys_clk_i, and software uses a plain strobe port with read data one
 * cycle after the read strobe.
 *
 * register map, word index then byte address:
 *   open-loop current reference     548h   1520h
 *   closed-loop speed reference     5CCh   1730h
 *   flux current reference          5FCh   17F0h
 *   torque current reference        5FEh   17F8h
 *   detection state                 67Ah   19E8h
 *   detection speed                 684h   1A10h
 *   interrupt status, write one     690h   1A40h
 *   interrupt mask                  692h   1A48h
 *
 * every value word but the detection state is a fraction with 27 fractional bits. currents
 * scale by 1.25 A, speeds by the configured maximum speed; the bank
 * keeps raw words and leaves the scaling to software.
 *
 * detection state codes, low 16 bits of the state word:
 *   0 initialising, 1 stop check, 2 direction check, 3 done, 4 error
 *
 * interrupt events: entry into the done code, entry into the error
 * code, and every load of the closed-loop speed reference. a flag
 * stays set until software writes a one to it, and an event in the
 * same cycle as that write keeps it set. the interrupt output is high
 * while any unmasked flag is set.
 *
 * limitation: a load and a read of the same word in one cycle return
 * the old value; the new one is readable from the next cycle on.
 *
 */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.vh"

module mcr_ref_status #(
  parameter ADDR_WIDTH = 14
) (
  input  wire                  sys_clk_i,
  input  wire                  nrst_i,
  // software port, byte addresses
  input  wire [ADDR_WIDTH-1:0] addr_i,
  input  wire [31:0]           wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  output reg  [31:0]           rdata_o,
  output reg                   rd_err_o,
  // algorithm side updates
  input  wire                  open_loop_current_load_i,
  input  wire [31:0]           open_loop_current_i,
  input  wire                  closed_loop_speed_load_i,
  input  wire [31:0]           closed_loop_speed_i,
  input  wire                  flux_current_load_i,
  input  wire [31:0]           flux_current_i,
  input  wire                  torque_current_load_i,
  input  wire [31:0]           torque_current_i,
  input  wire                  detect_state_load_i,
  input  wire [15:0]           detect_state_i,
  input  wire                  detect_speed_load_i,
  input  wire [31:0]           detect_speed_i,
  // interrupt
  output wire                  irq_o
);

  // ============================================================
  // address decode helper
  // the bank is word addressed; misaligned byte addresses never hit
  function hit;
    input [ADDR_WIDTH-1:0] byte_addr;
    input [`MCR_IDX_WIDTH-1:0] idx;
    begin
      hit = (byte_addr[`MCR_BYTE_SHIFT-1:0] == {`MCR_BYTE_SHIFT{1'b0}}) &&
            (byte_addr[ADDR_WIDTH-1:`MCR_BYTE_SHIFT] ==
             idx[ADDR_WIDTH-`MCR_BYTE_SHIFT-1:0]);
    end
  endfunction

  // ============================================================
  // register selects
  // each word is decoded once here for the read mux, and the two interrupt
  // words also feed the two write enables, so the map cannot drift between the two paths
  wire sel_open_loop;
  wire sel_closed_speed;
  wire sel_flux;
  wire sel_torque;
  wire sel_det_state;
  wire sel_det_speed;
  wire sel_irq_status;
  wire sel_irq_mask;
  wire sel_any;

  assign sel_open_loop    = hit(addr_i, `MCR_IDX_OPEN_LOOP_CURRENT);
  assign sel_closed_speed = hit(addr_i, `MCR_IDX_CLOSED_LOOP_SPEED);
  assign sel_flux         = hit(addr_i, `MCR_IDX_FLUX_CURRENT);
  assign sel_torque       = hit(addr_i, `MCR_IDX_TORQUE_CURRENT);
  assign sel_det_state    = hit(addr_i, `MCR_IDX_DETECT_STATE);
  assign sel_det_speed    = hit(addr_i, `MCR_IDX_DETECT_SPEED);
  assign sel_irq_status   = hit(addr_i, `MCR_IDX_IRQ_STATUS);
  assign sel_irq_mask     = hit(addr_i, `MCR_IDX_IRQ_MASK);

  // a misaligned or unmapped address selects nothing, reads as an error
  assign sel_any = sel_open_loop  | sel_closed_speed | sel_flux      |
                   sel_torque     | sel_det_state    | sel_det_speed |
                   sel_irq_status | sel_irq_mask;

  // ============================================================
  // value storage
  // the bank keeps the raw word, so a read returns exactly what the
  // algorithm loaded, whatever scale software applies afterwards
  wire [31:0] open_loop_current_reference;
  wire [31:0] closed_loop_speed_reference;
  wire [31:0] flux_current_reference;
  wire [31:0] torque_current_reference;
  wire [15:0] speed_detect_state;
  wire [31:0] speed_detect_speed;

  // open-loop current reference: amperes are value / 2^27 * 1.25;
  // the scale is left to software, so no multiplier sits on this path
  mcr_value_reg #(.WIDTH(32)) u_open_loop (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (open_loop_current_load_i),
    .data_i    (open_loop_current_i),
    .value_o   (open_loop_current_reference)
  );

  // closed-loop speed target: hertz are value / 2^27 * maximum speed;
  // the maximum speed lives in the configuration, not in this bank
  mcr_value_reg #(.WIDTH(32)) u_closed_speed (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (closed_loop_speed_load_i),
    .data_i    (closed_loop_speed_i),
    .value_o   (closed_loop_speed_reference)
  );

  // d-axis current target of the flux loop, with the same 1.25 A
  // full scale as the open-loop reference
  mcr_value_reg #(.WIDTH(32)) u_flux (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (flux_current_load_i),
    .data_i    (flux_current_i),
    .value_o   (flux_current_reference)
  );

  // q-axis current target of the torque loop, again scaled by 1.25 A;
  // it changes every control period while the speed loop is closed
  mcr_value_reg #(.WIDTH(32)) u_torque (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (torque_current_load_i),
    .data_i    (torque_current_i),
    .value_o   (torque_current_reference)
  );

  // detection state: only 16 bits are kept and the upper half of the
  // word is tied to zero in the read mux; codes above 4 pass unfiltered
  mcr_value_reg #(.WIDTH(`MCR_STATE_WIDTH)) u_det_state (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (detect_state_load_i),
    .data_i    (detect_state_i),
    .value_o   (speed_detect_state)
  );

  // speed seen during initial detection, scaled like the speed target;
  // it keeps its last value after detection has finished
  mcr_value_reg #(.WIDTH(32)) u_det_speed (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (detect_speed_load_i),
    .data_i    (detect_speed_i),
    .value_o   (speed_detect_speed)
  );

  // ============================================================
  // interrupt events from the detection sequence and the speed target loads
  wire [`MCR_IRQ_WIDTH-1:0] irq_event;
  wire [`MCR_IRQ_WIDTH-1:0] irq_status;
  wire [`MCR_IRQ_WIDTH-1:0] irq_mask;
  wire                      wr_status;
  wire                      wr_mask;

  // events fire on entry into a code, not while it is held: the stored
  // state still holds the code before this load, so a repeated load of
  // the same code finds it equal and raises nothing
  wire                      enter_done;
  wire                      enter_error;

  assign enter_done  = detect_state_load_i &&
                       (detect_state_i == `MCR_DETECT_DONE) &&
                       (speed_detect_state != `MCR_DETECT_DONE);
  assign enter_error = detect_state_load_i &&
                       (detect_state_i == `MCR_DETECT_ERROR) &&
                       (speed_detect_state != `MCR_DETECT_ERROR);

  assign irq_event[`MCR_IRQ_BIT_DONE]       = enter_done;
  assign irq_event[`MCR_IRQ_BIT_ERROR]      = enter_error;
  // every load of the speed target counts, even an unchanged value
  assign irq_event[`MCR_IRQ_BIT_REF_UPDATE] = closed_loop_speed_load_i;

  // only the interrupt registers accept writes; a write to a value
  // register or to an unmapped word enables nothing and is dropped
  assign wr_status = wr_i && sel_irq_status;
  assign wr_mask   = wr_i && sel_irq_mask;

  // the flag block keeps status and mask; a clear and an event in the
  // same cycle resolve in favour of the event so nothing is lost
  mcr_irq_ctrl #(.WIDTH(`MCR_IRQ_WIDTH)) u_irq (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .event_i    (irq_event),
    .clear_wr_i (wr_status),
    .mask_wr_i  (wr_mask),
    .wdata_i    (wdata_i[`MCR_IRQ_WIDTH-1:0]),
    .status_o   (irq_status),
    .mask_o     (irq_mask),
    .irq_o      (irq_o)
  );

  // ============================================================
  // read mux; writes to the reference bank fall through unused
  // the selects are one-hot, so the order of the branches below only
  // matters for reading the code, never for the result
  reg [31:0] next_rdata;
  reg        next_err;

  always @* begin
    next_rdata = `MCR_RESET_WORD;
    // unmapped reads answer zero with an error flag
    next_err   = ~sel_any;
    if (sel_open_loop) begin
      next_rdata = open_loop_current_reference;
    end else if (sel_closed_speed) begin
      next_rdata = closed_loop_speed_reference;
    end else if (sel_flux) begin
      next_rdata = flux_current_reference;
    end else if (sel_torque) begin
      next_rdata = torque_current_reference;
    end else if (sel_det_state) begin
      next_rdata = {{(32-`MCR_STATE_WIDTH){1'b0}},
                    speed_detect_state};
    end else if (sel_det_speed) begin
      next_rdata = speed_detect_speed;
    end else if (sel_irq_status) begin
      next_rdata = {{(32-`MCR_IRQ_WIDTH){1'b0}}, irq_status};
    end else if (sel_irq_mask) begin
      next_rdata = {{(32-`MCR_IRQ_WIDTH){1'b0}}, irq_mask};
    end
  end

  // read data stand only in the cycle after the read strobe
  // the word drops back to zero after one cycle, so a master that looks
  // late sees zero rather than a stale value; reads never stall
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o  <= `MCR_RESET_WORD;
      rd_err_o <= 1'b0;
    end else if (rd_i) begin
      rdata_o  <= next_rdata;
      rd_err_o <= next_err;
    end else begin
      rdata_o  <= `MCR_RESET_WORD;
      rd_err_o <= 1'b0;
    end
  end

  // ============================================================
  // write path
  // the six value registers have no software write enable at all:
  // their only load strobes come from the algorithm side, so a stray
  // write cannot disturb a reference that the control loop is using.
  // writes to them, and to unmapped words, simply fall away

endmodule
`default_nettype wire

/* File: hdl/mcr_regs.vh */
/*
 * register map, field layout and reset values of the reference and
 * speed-detection status bank. assumes inclusion by the bank and its
 * helpers only; holds definitions and nothing else.
 */
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

// ============================================================
// register word index; the byte address is four times the index
`define MCR_IDX_OPEN_LOOP_CURRENT   12'h548
`define MCR_IDX_CLOSED_LOOP_SPEED   12'h5CC
`define MCR_IDX_FLUX_CURRENT        12'h5FC
`define MCR_IDX_TORQUE_CURRENT      12'h5FE
`define MCR_IDX_DETECT_STATE        12'h67A
`define MCR_IDX_DETECT_SPEED        12'h684
`define MCR_IDX_IRQ_STATUS          12'h690
`define MCR_IDX_IRQ_MASK            12'h692
`define MCR_IDX_WIDTH               12

// byte address shift: two low address bits select a byte
`define MCR_BYTE_SHIFT              2

// ============================================================
// field layout
`define MCR_STATE_WIDTH             16
`define MCR_IRQ_WIDTH               3
`define MCR_IRQ_BIT_DONE            0
`define MCR_IRQ_BIT_ERROR           1
`define MCR_IRQ_BIT_REF_UPDATE      2

// ============================================================
// initial speed detection state codes
`define MCR_DETECT_INITIALISING     16'h0000
`define MCR_DETECT_STOP_CHECK       16'h0001
`define MCR_DETECT_DIRECTION_CHECK  16'h0002
`define MCR_DETECT_DONE             16'h0003
`define MCR_DETECT_ERROR            16'h0004

// ============================================================
// reset values
`define MCR_RESET_WORD              32'h00000000
`define MCR_RESET_STATE             16'h0000
`define MCR_RESET_IRQ               3'h0

`endif

/* File: hdl/mcr_value_reg.v */
/*
 * one captured value of WIDTH bits (32 by default) with a load strobe.
 * assumes the load strobe and data come from logic on sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.vh"

module mcr_value_reg #(
  parameter WIDTH = 32
) (
  input  wire             sys_clk_i,
  input  wire             nrst_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] value_o
);

  // ============================================================
  // storage: cleared by reset, loaded only by the algorithm side
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value_o <= {WIDTH{1'b0}};
    end else if (load_i) begin
      value_o <= data_i;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/mcr_irq_ctrl.v */
/*
 * sticky event flags, write-one-to-clear, with a mask and one level
 * interrupt. assumes events and bus strobes come from sys_clk_i logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.vh"

module mcr_irq_ctrl #(
  parameter WIDTH = 3
) (
  input  wire             sys_clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] event_i,
  input  wire             clear_wr_i,
  input  wire             mask_wr_i,
  input  wire [WIDTH-1:0] wdata_i,
  output reg  [WIDTH-1:0] status_o,
  output reg  [WIDTH-1:0] mask_o,
  output wire             irq_o
);

  // ============================================================
  // sticky flags: a new event wins over a clear in the same cycle
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_o <= {WIDTH{1'b0}};
      mask_o   <= {WIDTH{1'b0}};
    end else begin
      status_o <= (status_o & ~(clear_wr_i ? wdata_i : {WIDTH{1'b0}}))
                  | event_i;
      if (mask_wr_i) begin
        mask_o <= wdata_i;
      end
    end
  end

  // level interrupt while any enabled flag stands
  assign irq_o = |(status_o & mask_o);

endmodule
`default_nettype wire

/* File: verification/mcr_ref_status_assertions.sv */
/* checker for mcr_ref_status; sees only its ports through bind */
`timescale 1ns/1ps
`default_nettype none
module mcr_ref_status_assertions #(parameter ADDR_WIDTH = 14) (
  input wire logic                  sys_clk_i,
  input wire logic                  nrst_i,
  input wire logic [ADDR_WIDTH-1:0] addr_i,
  input wire logic                  rd_i,
  input wire logic [31:0]           rdata_o,
  input wire logic                  rd_err_o,
  input wire logic                  open_loop_current_load_i,
  input wire logic [31:0]           open_loop_current_i,
  input wire logic                  closed_loop_speed_load_i,
  input wire logic [31:0]           closed_loop_speed_i,
  input wire logic                  flux_current_load_i,
  input wire logic [31:0]           flux_current_i,
  input wire logic                  torque_current_load_i,
  input wire logic [31:0]           torque_current_i,
  input wire logic                  detect_state_load_i,
  input wire logic [15:0]           detect_state_i,
  input wire logic                  detect_speed_load_i,
  input wire logic [31:0]           detect_speed_i,
  input wire logic                  irq_o
);
  // ==========================================================
  // shadows ignore writes, so reads against them also catch write leaks
  logic [31:0] sh [6];
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < 6; k++) sh[k] <= 32'h0;
    end else begin
      if (open_loop_current_load_i) sh[0] <= open_loop_current_i;
      if (closed_loop_speed_load_i) sh[1] <= closed_loop_speed_i;
      if (flux_current_load_i) sh[2] <= flux_current_i;
      if (torque_current_load_i) sh[3] <= torque_current_i;
      if (detect_state_load_i) sh[4] <= {16'h0, detect_state_i};
      if (detect_speed_load_i) sh[5] <= detect_speed_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // read port
  a_read_idle: assert property (!$past(rd_i) |-> !rdata_o && !rd_err_o)
    else $error("read data outside read cycle");
  a_reset_clear: assert property ($rose(nrst_i) |-> !rdata_o && !irq_o)
    else $error("not clear after reset");
  a_open_loop: assert property (rd_i && addr_i == 14'h1520 |=>
    rdata_o == $past(sh[0])) else $error("open-loop reference wrong");
  a_speed_ref: assert property (rd_i && addr_i == 14'h1730 |=>
    rdata_o == $past(sh[1])) else $error("speed reference wrong");
  a_flux_ref: assert property (rd_i && addr_i == 14'h17F0 |=>
    rdata_o == $past(sh[2])) else $error("flux reference wrong");
  a_torque_ref: assert property (rd_i && addr_i == 14'h17F8 |=>
    rdata_o == $past(sh[3])) else $error("torque reference wrong");
  a_detect_state: assert property (rd_i && addr_i == 14'h19E8 |=>
    rdata_o == $past(sh[4])) else $error("detect state wrong");
  a_detect_speed: assert property (rd_i && addr_i == 14'h1A10 |=>
    rdata_o == $past(sh[5])) else $error("detect speed wrong");
  a_misaligned_err: assert property (rd_i && addr_i[1:0] != 2'h0 |=>
    rd_err_o && !rdata_o) else $error("misaligned read accepted");
endmodule
bind mcr_ref_status mcr_ref_status_assertions
  #(.ADDR_WIDTH(ADDR_WIDTH)) mcr_ref_status_assertions_i (.*);
`default_nettype wire

/* File: verification/mcr_ref_status_tb.sv */
/* bench for mcr_ref_status: loads values, reads them back, runs irq;
   assumes the checker is bound in from its own file */
`timescale 1ns/1ps
`default_nettype none
module mcr_ref_status_tb;
  logic        sys_clk_i, nrst_i, wr_i, rd_i, irq_o, rd_err_o;
  logic [13:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [5:0]  ld;
  logic [31:0] val [6];
  logic [31:0] exp_v [6];
  logic [31:0] seed = 32'h6FA99976;
  logic [13:0] adr [8] = '{14'h1520, 14'h1730, 14'h17F0, 14'h17F8,
                           14'h19E8, 14'h1A10, 14'h1A40, 14'h1A48};
  int          mismatches = 0, tests_run = 0, cyc = 0;
  mcr_ref_status #(.ADDR_WIDTH(14)) mcr_ref_status_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rd_err_o(rd_err_o), .irq_o(irq_o),
    .open_loop_current_load_i(ld[0]), .open_loop_current_i(val[0]),
    .closed_loop_speed_load_i(ld[1]), .closed_loop_speed_i(val[1]),
    .flux_current_load_i(ld[2]), .flux_current_i(val[2]),
    .torque_current_load_i(ld[3]), .torque_current_i(val[3]),
    .detect_state_load_i(ld[4]), .detect_state_i(val[4][15:0]),
    .detect_speed_load_i(ld[5]), .detect_speed_i(val[5]));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // the state word keeps only its low half; the rest read as zero
  function automatic logic [31:0] expect_word(input int i,
                                              input logic [31:0] v);
    return (i == 4) ? {16'h0, v[15:0]} : v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_irq(input logic want);
    #1;
    chk({31'h0, irq_o}, {31'h0, want});
  endtask
  // read data is looked at only in the single cycle it stands
  task automatic rd(input logic [13:0] a, input logic [31:0] w,
                    input logic err);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, w);
    chk({31'h0, rd_err_o}, {31'h0, err});
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic load(input int i, input logic [31:0] v);
    @(posedge sys_clk_i);
    ld[i] <= 1'b1;
    val[i] <= v;
    exp_v[i] <= expect_word(i, v);
    @(posedge sys_clk_i);
    ld <= 6'h0;
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {wr_i, rd_i, ld, addr_i, wdata_i} = '0;
    for (int k = 0; k < 6; k++) begin
      val[k] = 32'h0;
      exp_v[k] = 32'h0;
    end
    nrst_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 8; k++) rd(adr[k], 32'h0, 1'b0);
    // random updates, read back, then a software write that must not land
    for (int n = 0; n < 60; n++) begin
      int i;
      i = xs() % 6;
      load(i, xs());
      rd(adr[i], exp_v[i], 1'b0);
      wr(adr[i], xs());
      rd(adr[i], exp_v[i], 1'b0);
    end
    // every state code, with junk in the upper half of the input word
    for (int c = 0; c < 5; c++) begin
      load(4, (xs() & 32'hFFFF0000) | c);
      rd(adr[4], c, 1'b0);
    end
    rd(14'h1522, 32'h0, 1'b1);
    rd(14'h0000, 32'h0, 1'b1);
    // interrupt: clear stale flags, raise, mask, clear
    wr(adr[7], 32'h7);
    wr(adr[6], 32'h7);
    rd(adr[6], 32'h0, 1'b0);
    load(4, 32'h3);
    rd(adr[6], 32'h1, 1'b0);
    chk_irq(1'b1);
    wr(adr[7], 32'h6);
    chk_irq(1'b0);
    load(4, 32'h4);
    rd(adr[6], 32'h3, 1'b0);
    chk_irq(1'b1);
    wr(adr[6], 32'h3);
    rd(adr[6], 32'h0, 1'b0);
    chk_irq(1'b0);
    load(1, xs());
    rd(adr[6], 32'h4, 1'b0);
    chk_irq(1'b1);
    // an event in the same cycle as its clear keeps the flag set
    @(posedge sys_clk_i);
    ld[1] <= 1'b1;
    val[1] <= xs();
    wr_i <= 1'b1;
    addr_i <= adr[6];
    wdata_i <= 32'h4;
    @(posedge sys_clk_i);
    ld <= 6'h0;
    wr_i <= 1'b0;
    rd(adr[6], 32'h4, 1'b0);
    // reset in mid-run wipes the bank and the flags
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 8; k++) rd(adr[k], 32'h0, 1'b0);
    chk_irq(1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
